// file: hdl/tws_consts.vh
// Constants for the two-wire register access slave
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// Slave addresses (7-bit); base pair and the page 2/3 pair one above
`define TWS_BASE_ADDR 7'h68
`define TWS_HIGH_ADDR 7'h69

// Page control register sits at byte offset 0x0 of each half page
`define TWS_PAGE_CTRL_OFS 7'h00
`define TWS_PAGE_CTRL_RST 8'h00
`define TWS_PC_RETURN_BIT 7
`define TWS_PC_WMODE_BIT 6
`define TWS_PC_PAGE_MSB 1

// Protocol states
`define TWS_ST_IDLE 3'h0
`define TWS_ST_RX 3'h1
`define TWS_ST_ACK 3'h2
`define TWS_ST_TX 3'h3
`define TWS_ST_RACK 3'h4
`define TWS_ST_WAIT 3'h5

// Byte roles within a frame
`define TWS_KIND_SLAVE 2'h0
`define TWS_KIND_REG 2'h1
`define TWS_KIND_DATA 2'h2

// Clock stall timeout: 35 ms at 10 MHz (100 ns period)
`define TWS_STALL_MS 35
`define TWS_CLK_NS 100
`define TWS_STALL_CYC ((`TWS_STALL_MS * 1000000) / `TWS_CLK_NS)

`endif

// file: hdl/tws_cond_det.v
// Bus line edge and START/STOP condition detector
`timescale 1ns/10ps
`include "tws_consts.vh"

module tws_cond_det (
	mclk,
	rst_b,
	scl_i,
	sda_i,
	scl_rise,
	scl_fall,
	start_det,
	stop_det,
	bus_still
);
	input wire mclk;
	input wire rst_b;
	input wire scl_i;
	input wire sda_i;
	output wire scl_rise;
	output wire scl_fall;
	output wire start_det;
	output wire stop_det;
	output wire bus_still;

	reg scl_q_ff;
	reg sda_q_ff;

	// Previous line levels, idle-high after reset
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q_ff <= 1'h1;
			sda_q_ff <= 1'h1;
		end else begin
			scl_q_ff <= scl_i;
			sda_q_ff <= sda_i;
		end
	end

	// Edges and conditions; SDA change while SCL high is a condition
	assign scl_rise = scl_i & ~scl_q_ff;
	assign scl_fall = ~scl_i & scl_q_ff;
	assign start_det = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
	assign stop_det = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
	assign bus_still = (scl_i == scl_q_ff);

endmodule // tws_cond_det

// file: hdl/tws_slave.v
// Two-wire register access slave engine
// What this block does
// (R1) The host writes the register address, then reads after a START.
// (R2) The host ends a read with a not-acknowledge, then a STOP.
// (R3) A host acknowledge on a read byte steps the pointer and sends on.
// (R4) Reading an address that does not exist returns an all-zero byte.
// (R5) After a repeated START the host repeats the same slave address.
// (R6) Default write mode stores each data byte at the next address.
// (R7) Alternating mode takes address and data bytes in turn.
// (R8) A write-mode change takes effect only from the next START.
// (R9) A STOP in mid-message abandons it and returns to idle; a START restarts address reception.
// (R10) Every byte of a write, address and data alike, is acknowledged.
// (R11) Page control selects the page, or returns to zero with auto return.
// (R12) The slave address one above the base pair opens pages two and three.
// (R13) With the stall timeout on, a bus clock stalled 35 ms resets the link.
`timescale 1ns/10ps
`include "tws_consts.vh"

module tws_slave #(
	parameter STALL_CYC = `TWS_STALL_CYC
) (
	mclk,
	rst_b,
	scl_i,
	sda_i,
	sda_o,
	sda_oe,
	clock_stall_timeout_enable,
	reg_rdata,
	reg_exists,
	reg_addr_ff,
	reg_wdata_ff,
	reg_wr_ff,
	page_control_ff
);
	input wire mclk;
	input wire rst_b;
	input wire scl_i;
	input wire sda_i;
	output reg sda_o;
	output reg sda_oe;
	input wire clock_stall_timeout_enable;
	input wire [7:0] reg_rdata;
	input wire reg_exists;
	output reg [8:0] reg_addr_ff;
	output reg [7:0] reg_wdata_ff;
	output reg reg_wr_ff;
	output reg [7:0] page_control_ff;

	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire bus_still;
	wire stall_hit;
	wire is_pc;
	wire [7:0] rd_byte;
	reg [2:0] state_ff;
	reg [1:0] kind_ff;
	reg [3:0] cnt_ff;
	reg [7:0] sh_ff;
	reg rw_ff;
	reg alt_frame_ff;
	reg alt_addr_ff;
	reg inc_pend_ff;
	reg [31:0] stall_ff;

	// Engine states and byte roles, binary coded
	localparam ST_IDLE = `TWS_ST_IDLE;
	localparam ST_RX = `TWS_ST_RX;
	localparam ST_ACK = `TWS_ST_ACK;
	localparam ST_TX = `TWS_ST_TX;
	localparam ST_RACK = `TWS_ST_RACK;
	localparam ST_WAIT = `TWS_ST_WAIT;
	localparam KIND_SLAVE = `TWS_KIND_SLAVE;
	localparam KIND_REG = `TWS_KIND_REG;
	localparam KIND_DATA = `TWS_KIND_DATA;

	tws_cond_det u_det (
		.mclk(mclk),
		.rst_b(rst_b),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det),
		.bus_still(bus_still)
	);

	// Page control answers at offset zero of either half page
	assign is_pc = (reg_addr_ff[6:0] == `TWS_PAGE_CTRL_OFS);
	// Missing registers read as zero
	assign rd_byte = is_pc ? page_control_ff :
		(reg_exists ? reg_rdata : 8'h00); // R4
	// Stall counter reaches its limit
	assign stall_hit = clock_stall_timeout_enable &&
		(stall_ff >= STALL_CYC - 1); // R13

	// Clock stall watchdog, only counts inside a frame
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stall_ff <= 32'h0;
		end else if (state_ff == ST_IDLE || !bus_still) begin
			stall_ff <= 32'h0;
		end else if (!stall_hit) begin
			stall_ff <= stall_ff + 32'h1; // R13
		end
	end

	// Protocol engine
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= ST_IDLE;
			kind_ff <= KIND_SLAVE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			rw_ff <= 1'h0;
			alt_frame_ff <= 1'h0;
			alt_addr_ff <= 1'h0;
			inc_pend_ff <= 1'h0;
			sda_o <= 1'h0;
			sda_oe <= 1'h0;
			reg_addr_ff <= 9'h000;
			reg_wdata_ff <= 8'h00;
			reg_wr_ff <= 1'h0;
			page_control_ff <= `TWS_PAGE_CTRL_RST;
		end else begin
			reg_wr_ff <= 1'h0;
			sda_o <= 1'h0;
			if (stall_hit) begin
				state_ff <= ST_IDLE; // R13
				sda_oe <= 1'h0;
			end else if (stop_det) begin
				// Abandon frame; optional return to page zero
				state_ff <= ST_IDLE; // R9
				sda_oe <= 1'h0;
				if (page_control_ff[`TWS_PC_RETURN_BIT]) begin
					page_control_ff[`TWS_PC_PAGE_MSB:0] <= 2'h0; // R11
				end
			end else if (start_det) begin
				// New or repeated START restarts address reception
				state_ff <= ST_RX; // R9
				kind_ff <= KIND_SLAVE;
				cnt_ff <= 4'h0;
				sda_oe <= 1'h0;
				alt_frame_ff <= page_control_ff[`TWS_PC_WMODE_BIT]; // R8
				alt_addr_ff <= 1'h0;
			end else begin
				case (state_ff)
				ST_RX: begin
					if (scl_rise && cnt_ff < 4'h8) begin
						sh_ff <= {sh_ff[6:0], sda_i};
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == 4'h8) begin
						cnt_ff <= 4'h0;
						state_ff <= ST_ACK;
						sda_oe <= 1'h1; // R10
						case (kind_ff)
						KIND_SLAVE: begin
							if (sh_ff[7:1] == `TWS_BASE_ADDR ||
								sh_ff[7:1] == `TWS_HIGH_ADDR) begin
								rw_ff <= sh_ff[0];
								reg_addr_ff[8] <= (sh_ff[7:1] == // R12
									`TWS_HIGH_ADDR) ? 1'h1 :
									page_control_ff[`TWS_PC_PAGE_MSB];
							end else begin
								state_ff <= ST_WAIT;
								sda_oe <= 1'h0;
							end
						end
						KIND_REG: begin
							reg_addr_ff[7:0] <= sh_ff;
							kind_ff <= KIND_DATA;
							alt_addr_ff <= 1'h0;
						end
						default: begin
							if (alt_frame_ff && alt_addr_ff) begin
								reg_addr_ff[7:0] <= sh_ff; // R7
								alt_addr_ff <= 1'h0;
							end else begin
								// Store, then step in default mode
								if (is_pc) begin
									page_control_ff <= sh_ff; // R11
								end else begin
									reg_wr_ff <= 1'h1;
								end
								reg_wdata_ff <= sh_ff;
								inc_pend_ff <= ~alt_frame_ff; // R6
								alt_addr_ff <= alt_frame_ff; // R7
							end
						end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						inc_pend_ff <= 1'h0;
						if (inc_pend_ff) begin
							reg_addr_ff[7:0] <= reg_addr_ff[7:0] + 8'h01;
						end
						if (kind_ff == KIND_SLAVE && rw_ff) begin
							// Read: first byte from current pointer
							state_ff <= ST_TX; // R1
							sh_ff <= {rd_byte[6:0], 1'h0};
							sda_oe <= ~rd_byte[7];
							cnt_ff <= 4'h1;
						end else begin
							if (kind_ff == KIND_SLAVE) begin
								kind_ff <= KIND_REG;
							end
							state_ff <= ST_RX;
							sda_oe <= 1'h0;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_ff == 4'h8) begin
							sda_oe <= 1'h0;
							state_ff <= ST_RACK;
						end else begin
							sda_oe <= ~sh_ff[7];
							sh_ff <= {sh_ff[6:0], 1'h0};
							cnt_ff <= cnt_ff + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						if (!sda_i) begin
							// Host acknowledged: step pointer
							reg_addr_ff[7:0] <= reg_addr_ff[7:0] + 8'h01; // R3
						end else begin
							state_ff <= ST_WAIT; // R2
						end
					end else if (scl_fall) begin
						state_ff <= ST_TX; // R3
						sh_ff <= {rd_byte[6:0], 1'h0};
						sda_oe <= ~rd_byte[7];
						cnt_ff <= 4'h1;
					end
				end
				ST_WAIT: begin
					sda_oe <= 1'h0;
				end
				default: begin
					state_ff <= ST_IDLE;
					sda_oe <= 1'h0;
				end
				endcase
			end
		end
	end

endmodule // tws_slave

// file: testbench/tws_slave_monitor.sv
// Port checker for the two-wire slave
`timescale 1ns/10ps
module tws_monitor #(
	parameter STALL_CYC = 350000
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic clock_stall_timeout_enable,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_exists,
	input wire logic [8:0] reg_addr_ff,
	input wire logic [7:0] reg_wdata_ff,
	input wire logic reg_wr_ff,
	input wire logic [7:0] page_control_ff
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	int still_ff;
	// Clocks of a static bus clock while the timeout is on
	always @(posedge mclk or negedge rst_b)
		if (!rst_b)
			still_ff <= 0;
		else if ($stable(scl_i) && clock_stall_timeout_enable)
			still_ff <= still_ff + 1;
		else
			still_ff <= 0;
	// Write strobe, acknowledge and line drive
	a_wr_single: assert property (reg_wr_ff |=> !reg_wr_ff)
		else $error("write pulse long");
	a_wr_stable: assert property (reg_wr_ff |=> $stable(reg_addr_ff)
		&& $stable(reg_wdata_ff)) else $error("write bus moved");
	a_wr_ack: assert property (reg_wr_ff |-> $rose(sda_oe))
		else $error("write without ack");
	a_ack_hold: assert property (reg_wr_ff |=> sda_oe [*3])
		else $error("ack short");
	a_ctrl_nowr: assert property (reg_wr_ff |-> reg_addr_ff[6:0] != 7'h00)
		else $error("page control strobed");
	a_oe_steady: assert property (scl_i && $past(scl_i) &&
		!clock_stall_timeout_enable |-> $stable(sda_oe)) else $error("sda moved");
	a_stall_free: assert property (still_ff > STALL_CYC + 8 |-> !sda_oe)
		else $error("stall kept bus");
	a_open_drain: assert property (sda_o == 1'h0)
		else $error("sda driven high");
	// Main scenarios reached
	c_write: cover property (reg_wr_ff);
	c_stall: cover property (still_ff == STALL_CYC);
	c_alt: cover property ($rose(page_control_ff[6]));
endmodule  // tws_monitor
bind tws_slave tws_monitor #(.STALL_CYC(STALL_CYC)) u_mon (.*);

// file: testbench/tws_host.sv
// Host master model on the two-wire bus
`timescale 1ns/10ps
module tws_host (
	input wire logic mclk,
	input wire logic sda,
	output logic scl = 1'h1,
	output logic hoe = 1'h0
);
	int nak_cnt = 0;
	// Set both lines, hold four clocks
	task automatic step(input logic c, input logic o);
		scl <= c;
		hoe <= o;
		repeat (4) @(negedge mclk);
	endtask
	// Data moves only while the clock is low
	task automatic xbit(input logic v, output logic r);
		step(1'h0, !v);
		step(1'h1, !v);
		r = sda;
		step(1'h0, !v);
	endtask
	// Byte then acknowledge; unanswered slave bytes counted
	task automatic xbyte(input logic [7:0] v, input logic ak,
		output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--)
			xbit(v[i], r[i]);
		xbit(ak, a);
		if (ak && a && v != 8'hff)
			nak_cnt++;
	endtask
	task automatic start();
		step(1'h0, 1'h0);
		step(1'h1, 1'h0);
		step(1'h1, 1'h1);
		step(1'h0, 1'h1);
	endtask
	task automatic stop();
		step(1'h0, 1'h1);
		step(1'h1, 1'h1);
		step(1'h1, 1'h0);
	endtask
	// Whole write frame ended by a stop
	task automatic wr(input logic [6:0] s, input logic [7:0] b[$]);
		logic [7:0] r;
		start();
		xbyte({s, 1'h0}, 1'h1, r);
		foreach (b[i])
			xbyte(b[i], 1'h1, r);
		stop();
	endtask
	// Pointer write, repeated start, same address, last byte refused
	task automatic rd(input logic [7:0] a, input int n,
		output logic [7:0] q[$]);
		logic [7:0] r;
		q = {};
		start();
		xbyte(8'hd0, 1'h1, r);
		xbyte(a, 1'h1, r);
		start();
		xbyte(8'hd1, 1'h1, r);
		for (int i = 1; i <= n; i++) begin
			xbyte(8'hff, i == n, r);
			q.push_back(r);
		end
		stop();
	endtask
endmodule  // tws_host

// file: testbench/tb.sv
// Bench for the two-wire register access slave
`timescale 1ns/10ps
module tb;
	logic mclk = 1'h0, rst_b = 1'h0, clock_stall_timeout_enable = 1'h0;
	logic scl_i, sda_i, sda_o, sda_oe, reg_exists, reg_wr_ff, hoe, b;
	logic [7:0] reg_rdata, reg_wdata_ff, page_control_ff, d;
	logic [8:0] reg_addr_ff;
	logic [7:0] mem [512] = '{default: 8'h5a};
	logic [7:0] q[$];
	logic [23:0] rows [3] = '{24'h10a5a5, 24'h607700, 24'h902121};
	int err_total = 0;
	int checks = 0;
	always #50 mclk = ~mclk;
	// Pulled-up data wire; register file beside the slave
	assign sda_i = !(sda_oe | hoe);
	assign reg_exists = reg_addr_ff[6:0] < 7'h60;
	assign reg_rdata = mem[reg_addr_ff];
	always @(posedge mclk)
		if (reg_wr_ff)
			mem[reg_addr_ff] <= reg_wdata_ff;
	tws_slave #(.STALL_CYC(200)) u_dut (.*);
	tws_host h (.mclk, .sda(sda_i), .scl(scl_i), .hoe);
	task automatic chk(string n, logic [23:0] s, logic [23:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (40000) @(posedge mclk);
		err_total++;
		final_report();
	end
	initial begin
		repeat (20) @(negedge mclk);
		rst_b <= 1'h1;
		repeat (4) @(negedge mclk);
		foreach (rows[i]) begin
			h.wr(7'h68, {rows[i][23:16], rows[i][15:8]});
			h.rd(rows[i][23:16], 1, q);
			chk("row", q[0], rows[i][7:0]);
		end
		h.wr(7'h68, {8'h20, 8'h01, 8'h02, 8'h03});
		h.rd(8'h20, 3, q);
		chk("burst", {q[0], q[1], q[2]}, 24'h010203);
		// Frame cut by a start after four data bits
		h.start();
		h.xbyte(8'hd0, 1'h1, d);
		h.xbyte(8'h40, 1'h1, d);
		repeat (4) h.xbit(1'h0, b);
		h.wr(7'h68, {8'h41, 8'h07});
		chk("abort", {mem[9'h40], mem[9'h41]}, 24'h5a07);
		h.wr(7'h68, {8'h00, 8'h40, 8'h41});
		chk("same", mem[1], 8'h41);
		h.wr(7'h68, {8'h30, 8'h11, 8'h34, 8'h22, 8'h38});
		chk("alt", {mem[9'h30], mem[9'h34], mem[9'h31]}, 24'h11225a);
		h.wr(7'h68, {8'h00, 8'h82});
		chk("ret", page_control_ff, 8'h80);
		h.wr(7'h69, {8'h05, 8'h66});
		chk("hi", mem[9'h105], 8'h66);
		// Page two selected by page control, kept for the next frame
		h.wr(7'h68, {8'h00, 8'h02});
		h.wr(7'h68, {8'h07, 8'h3c});
		chk("page", mem[9'h107], 8'h3c);
		// Reset in mid-run clears page, write data and pointer
		rst_b <= 1'h0;
		repeat (2) @(negedge mclk);
		chk("rst page", page_control_ff, 8'h00);
		chk("rst ptr", {reg_wdata_ff, reg_addr_ff}, 24'h0);
		rst_b <= 1'h1;
		repeat (4) @(negedge mclk);
		// Address 0x68 write, then the clock stalls in the ack
		clock_stall_timeout_enable <= 1'h1;
		h.start();
		for (int i = 7; i >= 0; i--)
			h.xbit(i > 5 || i == 4, b);
		chk("ack", sda_oe, 1'h1);
		repeat (300) @(negedge mclk);
		chk("stall", sda_oe, 1'h0);
		clock_stall_timeout_enable <= 1'h0;
		h.stop();
		h.wr(7'h55, {8'h10, 8'h99});
		chk("nak", {mem[9'h10], 8'(h.nak_cnt)}, 24'ha503);
		final_report();
	end
endmodule  // tb
